//--- hw/bdio_port.sv
// banked 48-line digital i/o port with register interface
//
// Operation
// - two modes: standard, and enhanced which keeps standard behaviour
// - each line works as input, output, or output with readback
// - data moves one eight-line port at a time, chosen by address
// - mask register blocks writes to ports used as inputs
// - registers grouped into banks of eight byte-wide ports
// - standard: ports 0-5 carry lines, port 6 unused, port 7 mask
// - enhanced: event sense on all 48 lines, can raise interrupts
// - enhanced: software-selectable debounce before edge detection
// - enhanced banks: 0 i/o, 1 events and interrupts, 2 debounce
// - extra registers: interrupt enable with soft reset, and vector
// - decode from word address a1..a6, 64 words, part populated
// - every access is one byte on d0..d7
// - shared addresses split by read versus write direction
// - enhanced mode after 07h,0dh,06h,12h to port 7, undisturbed; keys ignored while irq enabled
// - standard mode after power-up or reset
// - unused addresses read zero; upper byte reads as ones
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
module bdio_port import bdio_pkg::*; #(
  parameter int DB_C0 = DB_CYC0,
  parameter int DB_C1 = DB_CYC1,
  parameter int DB_C2 = DB_CYC2,
  parameter int DB_C3 = DB_CYC3
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus
  input wire bdio_req_type req,
  output logic [15:0] rdata,
  output logic ack,
  // field lines, open drain, low-true
  input wire logic [47:0] line_in,
  output logic [47:0] line_out,
  output logic [47:0] line_oe,
  // interrupt and status
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic enh_mode
);
  // state
  bdio_mode_type mode_reg;
  bdio_mode_type mode_next;
  logic [47:0] out_reg;
  logic [5:0] mask_reg;
  logic [1:0] bank_reg;
  logic [47:0] evt_reg;
  logic [47:0] dbv_prev_reg;
  logic [11:0] pol_reg;
  logic [5:0] dben_reg;
  logic [1:0] dbsel_reg;
  logic [5:0] ie_reg;
  logic irq_en_reg;
  logic [7:0] vect_reg;
  logic srst_reg;
  logic irq_reg;
  logic [7:0] rdata_reg;
  logic ack_reg;
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [7:0] rd_byte;
  logic [47:0] line_log;
  logic [47:0] dbv;
  logic [47:0] out_wmask;
  logic [47:0] evt_clr;
  logic [47:0] evt_hit;
  logic [47:0] ie_line;

  // address decode; only a1..a6 exist on the bus
  wire enhanced = mode_reg == MD_ENH;
  wire acc = req.wr | req.rd;
  wire in_bank = req.addr[5:3] == BANK_AREA;
  wire [2:0] pidx = req.addr[2:0];
  wire is_line_port = in_bank & (pidx < 3'(NUM_PORTS));
  wire is_sel = in_bank & (pidx == PORT_SEL_IDX);
  wire [1:0] eff_bank = enhanced ? bank_reg : BANK_IO;
  wire wr_io = req.wr & is_line_port & (eff_bank == BANK_IO);
  wire wr_evt = req.wr & is_line_port & (eff_bank == BANK_EVT);
  wire wr_ie = req.wr & in_bank & (pidx == EVT_IE_IDX)
    & (eff_bank == BANK_EVT);
  wire wr_db = req.wr & in_bank & (eff_bank == BANK_DB);
  wire wr_sel = req.wr & is_sel;
  wire wr_ctrl = req.wr & (req.addr == WA_CTRL);
  wire wr_vect = req.wr & (req.addr == WA_VECT);

  // enhanced-mode unlock: key bytes only on port 7, irq disabled
  wire key_wr = wr_sel & !irq_en_reg;
  wire seq_brk = acc & !(is_sel & !irq_en_reg);
  wire [7:0] kd = req.wdata;

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MD_STD: begin
        if (key_wr && kd == KEY0) begin
          mode_next = MD_K1;
        end
      end
      MD_K1: begin
        if (key_wr && kd == KEY1) begin
          mode_next = MD_K2;
        end else if (key_wr && kd == KEY0) begin
          mode_next = MD_K1;
        end else if (key_wr || seq_brk) begin
          mode_next = MD_STD;
        end
      end
      MD_K2: begin
        if (key_wr && kd == KEY2) begin
          mode_next = MD_K3;
        end else if (key_wr && kd == KEY0) begin
          mode_next = MD_K1;
        end else if (key_wr || seq_brk) begin
          mode_next = MD_STD;
        end
      end
      MD_K3: begin
        if (key_wr && kd == KEY3) begin
          mode_next = MD_ENH;
        end else if (key_wr && kd == KEY0) begin
          mode_next = MD_K1;
        end else if (key_wr || seq_brk) begin
          mode_next = MD_STD;
        end
      end
      MD_ENH: begin
        mode_next = MD_ENH;
      end
      default: begin
        mode_next = MD_STD;
      end
    endcase
  end

  // pins are low-true: a low pin reads as logic one
  bdio_sync #(.WIDTH(NUM_LINES)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(~line_in),
    .dout(line_log)
  );

  // debounce sample tick; one shared prescaler, period chosen by software
  wire [TICK_W-1:0] tick_lim = (dbsel_reg == 2'h0) ? TICK_W'(DB_C0 - 1) :
    (dbsel_reg == 2'h1) ? TICK_W'(DB_C1 - 1) :
    (dbsel_reg == 2'h2) ? TICK_W'(DB_C2 - 1) : TICK_W'(DB_C3 - 1);
  wire db_tick = tick_cnt_reg >= tick_lim;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= db_tick ? '0 : tick_cnt_reg + TICK_W'(1);
    end
  end

  // per-port decode, debounce and event edges
  genvar p;
  genvar l;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      wire hit = pidx == 3'(p);
      assign out_wmask[p*8 +: 8] =
        {8{wr_io & hit & !mask_reg[p]}};
      assign evt_clr[p*8 +: 8] = {8{wr_evt & hit}} & req.wdata;
      assign ie_line[p*8 +: 8] = {8{ie_reg[p]}};
      bdio_debounce #(.WIDTH(PORT_W)) u_db (
        .clk(clk),
        .arst_n(arst_n),
        .en(dben_reg[p] & enhanced),
        .tick(db_tick),
        .din(line_log[p*8 +: 8]),
        .dout(dbv[p*8 +: 8])
      );
    end
    for (l = 0; l < NUM_LINES; l++) begin : g_edge
      // polarity one selects rising, zero falling, per nibble
      assign evt_hit[l] = pol_reg[l/4] ? (dbv[l] & !dbv_prev_reg[l]) :
        (!dbv[l] & dbv_prev_reg[l]);
    end
  endgenerate

  // next values of the data-path registers
  wire [47:0] out_next = (out_reg & ~out_wmask)
    | ({6{req.wdata}} & out_wmask);
  wire [47:0] evt_set = evt_hit & {48{enhanced}};
  wire [47:0] evt_next = (evt_reg & ~evt_clr) | evt_set; // set wins
  wire irq_next = irq_en_reg & enhanced & |(evt_reg & ie_line);
  wire [5:0] mask_next = req.wdata[SEL_MASK_LSB +: 6];
  wire [1:0] bank_next = enhanced ? req.wdata[SEL_BANK_LSB +: 2] : BANK_RST;

  // mode, mask, bank and line outputs; soft reset returns to standard
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= MD_STD;
      out_reg <= OUT_RST;
      mask_reg <= MASK_RST;
      bank_reg <= BANK_RST;
    end else if (srst_reg) begin
      mode_reg <= MD_STD;
      out_reg <= OUT_RST;
      mask_reg <= MASK_RST;
      bank_reg <= BANK_RST;
    end else begin
      mode_reg <= mode_next;
      out_reg <= out_next;
      mask_reg <= wr_sel ? mask_next : mask_reg;
      bank_reg <= wr_sel ? bank_next : bank_reg;
    end
  end

  // event status and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_reg <= '0;
      dbv_prev_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      evt_reg <= srst_reg ? '0 : evt_next;
      dbv_prev_reg <= dbv;
      irq_reg <= srst_reg ? 1'b0 : irq_next;
    end
  end

  // bank 1 and bank 2 configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ie_reg <= IE_RST;
      pol_reg <= POL_RST;
      dben_reg <= DBEN_RST;
      dbsel_reg <= DBSEL_RST;
    end else if (srst_reg) begin
      ie_reg <= IE_RST;
      pol_reg <= POL_RST;
      dben_reg <= DBEN_RST;
      dbsel_reg <= DBSEL_RST;
    end else begin
      if (wr_ie) begin
        ie_reg <= req.wdata[5:0];
      end
      if (wr_db && pidx == DB_POL_LO_IDX) begin
        pol_reg[7:0] <= req.wdata;
      end
      if (wr_db && pidx == DB_POL_HI_IDX) begin
        pol_reg[11:8] <= req.wdata[3:0];
      end
      if (wr_db && pidx == DB_EN_IDX) begin
        dben_reg <= req.wdata[5:0];
      end
      if (wr_db && pidx == DB_SEL_IDX) begin
        dbsel_reg <= req.wdata[1:0];
      end
    end
  end

  // control and vector; the vector survives a soft reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_reg <= 1'b0;
      srst_reg <= 1'b0;
      vect_reg <= VECT_RST;
    end else begin
      irq_en_reg <= srst_reg ? 1'b0 :
        (wr_ctrl ? req.wdata[CTRL_IRQ_EN_BIT] : irq_en_reg);
      srst_reg <= wr_ctrl & req.wdata[CTRL_SWRST_BIT];
      vect_reg <= wr_vect ? req.wdata : vect_reg;
    end
  end

  // read selection; lines read back the pin, not the output latch
  wire [7:0] line_byte = line_log[pidx*8 +: 8];
  wire [7:0] evt_byte = evt_reg[pidx*8 +: 8];
  wire [7:0] sel_byte = {enhanced ? bank_reg : BANK_RST, mask_reg};
  wire [7:0] io_rd = is_line_port ? line_byte : RD_UNUSED;
  wire [7:0] evt_rd = is_line_port ? evt_byte :
    (pidx == EVT_IE_IDX) ? {2'h0, ie_reg} : RD_UNUSED;
  wire [7:0] db_rd = (pidx == DB_POL_LO_IDX) ? pol_reg[7:0] :
    (pidx == DB_POL_HI_IDX) ? {4'h0, pol_reg[11:8]} :
    (pidx == DB_EN_IDX) ? {2'h0, dben_reg} :
    (pidx == DB_SEL_IDX) ? {6'h00, dbsel_reg} : RD_UNUSED;

  always_comb begin
    rd_byte = RD_UNUSED;
    if (is_sel) begin
      rd_byte = sel_byte;
    end else if (in_bank) begin
      unique case (eff_bank)
        BANK_IO: rd_byte = io_rd;
        BANK_EVT: rd_byte = evt_rd;
        BANK_DB: rd_byte = db_rd;
        default: rd_byte = RD_UNUSED;
      endcase
    end else if (req.addr == WA_CTRL) begin
      rd_byte = {7'h00, irq_en_reg};
    end else if (req.addr == WA_VECT) begin
      rd_byte = vect_reg;
    end
  end

  // answer one cycle after every strobe, mapped or not
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= RD_UNUSED;
      ack_reg <= 1'b0;
    end else begin
      rdata_reg <= req.rd ? rd_byte : RD_UNUSED;
      ack_reg <= acc;
    end
  end

  // outputs; the upper byte is never driven and reads as ones
  assign rdata = {HI_BYTE, rdata_reg};
  assign ack = ack_reg;
  assign line_out = '0;
  assign line_oe = out_reg;
  assign irq_req = irq_reg;
  assign irq_vector = vect_reg;
  assign enh_mode = enhanced;
endmodule

//--- shared/bdio_pkg.sv
// constants, types and register map for the banked digital i/o port
package bdio_pkg;
  // geometry
  localparam int NUM_LINES = 48;
  localparam int NUM_PORTS = 6;
  localparam int PORT_W = 8;
  localparam int ADDR_W = 6;
  localparam int NUM_NIBBLES = 12;
  // word addresses (a1..a6) and port indices inside a bank
  localparam logic [2:0] BANK_AREA = 3'h0;
  localparam logic [2:0] PORT_UNUSED_IDX = 3'h6;
  localparam logic [2:0] PORT_SEL_IDX = 3'h7;
  localparam logic [5:0] WA_CTRL = 6'h10;
  localparam logic [5:0] WA_VECT = 6'h11;
  // bank codes
  localparam logic [1:0] BANK_IO = 2'h0;
  localparam logic [1:0] BANK_EVT = 2'h1;
  localparam logic [1:0] BANK_DB = 2'h2;
  // bank 1 and bank 2 port indices
  localparam logic [2:0] EVT_IE_IDX = 3'h6;
  localparam logic [2:0] DB_POL_LO_IDX = 3'h0;
  localparam logic [2:0] DB_POL_HI_IDX = 3'h1;
  localparam logic [2:0] DB_EN_IDX = 3'h2;
  localparam logic [2:0] DB_SEL_IDX = 3'h3;
  // field positions
  localparam int SEL_MASK_LSB = 0;
  localparam int SEL_BANK_LSB = 6;
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_SWRST_BIT = 1;
  // enhanced mode unlock sequence
  localparam logic [7:0] KEY0 = 8'h07;
  localparam logic [7:0] KEY1 = 8'h0d;
  localparam logic [7:0] KEY2 = 8'h06;
  localparam logic [7:0] KEY3 = 8'h12;
  // reset values and fixed read values
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [1:0] BANK_RST = 2'h0;
  localparam logic [47:0] OUT_RST = 48'h0;
  localparam logic [11:0] POL_RST = 12'h000;
  localparam logic [5:0] DBEN_RST = 6'h00;
  localparam logic [1:0] DBSEL_RST = 2'h0;
  localparam logic [5:0] IE_RST = 6'h00;
  localparam logic [7:0] VECT_RST = 8'h00;
  localparam logic [7:0] HI_BYTE = 8'hff;
  localparam logic [7:0] RD_UNUSED = 8'h00;
  // debounce sample periods
  localparam int CLK_NS = 25;
  localparam int DB_T0_NS = 1000;
  localparam int DB_T1_NS = 16000;
  localparam int DB_T2_NS = 256000;
  localparam int DB_T3_NS = 4000000;
  localparam int DB_CYC0 = (DB_T0_NS + CLK_NS - 1) / CLK_NS;
  localparam int DB_CYC1 = (DB_T1_NS + CLK_NS - 1) / CLK_NS;
  localparam int DB_CYC2 = (DB_T2_NS + CLK_NS - 1) / CLK_NS;
  localparam int DB_CYC3 = (DB_T3_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W = 18;
  // register bus request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bdio_req_type;
  // operating mode, with the three partial unlock steps
  typedef enum logic [4:0] {
    MD_STD = 5'b00001,
    MD_K1 = 5'b00010,
    MD_K2 = 5'b00100,
    MD_K3 = 5'b01000,
    MD_ENH = 5'b10000
  } bdio_mode_type;
endpackage

//--- hw/bdio_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bdio_sync import bdio_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // raw and synchronised lines
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;
  wire [WIDTH-1:0] out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));

  // s1 feeds only s2; a bit moves once s2 and s3 agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end
  assign dout = out_reg;
endmodule

//--- hw/bdio_debounce.sv
// per-line debounce: a change must hold for three sample ticks
`timescale 1ns/1ps
module bdio_debounce import bdio_pkg::*; #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic en,
  input wire logic tick,
  // lines
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      logic [1:0] cnt_reg;
      logic val_reg;
      wire differ = din[i] != val_reg;
      wire settle = differ & tick & (cnt_reg == 2'h2);
      // disabled: follow the input through val_reg, one cycle late
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_reg <= 2'h0;
          val_reg <= 1'b0;
        end else if (!en || !differ || settle) begin
          cnt_reg <= 2'h0;
          val_reg <= en ? (settle ? din[i] : val_reg) : din[i];
        end else if (tick) begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
      assign dout[i] = val_reg;
    end
  endgenerate
endmodule

//--- bench/bdio_port_monitor.sv
// assertion checker for the banked digital i/o port
`timescale 1ns/1ps
module bdio_port_monitor import bdio_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register bus
  input wire bdio_req_type req,
  input wire logic [15:0] rdata,
  input wire logic ack,
  // field lines
  input wire logic [47:0] line_in,
  input wire logic [47:0] line_out,
  input wire logic [47:0] line_oe,
  // interrupt and status
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic enh_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] mask_reg;
  logic [5:0] mask_next;
  logic srst_wr;
  logic mask_hit;
  // shadow of the write mask; every port 7 write loads it
  assign srst_wr = req.wr && req.addr == WA_CTRL && req.wdata[1];
  assign mask_next = (req.wr && req.addr == 6'h07) ? req.wdata[5:0] :
                     srst_wr ? MASK_RST : mask_reg;
  assign mask_hit = req.addr < 6'h06 && mask_reg[req.addr[2:0]];
  // shadow of the design mask, cleared by soft reset one edge before the design
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= MASK_RST;
    end else begin
      mask_reg <= mask_next;
    end
  end
  ack_after_req_a: assert property ((req.wr || req.rd) |=> ack)
    else $error("request without ack");
  upper_byte_a: assert property (rdata[15:8] == HI_BYTE)
    else $error("upper data byte not ones");
  rdata_idle_a: assert property (!$past(req.rd) |->
    rdata[7:0] == 8'h00) else $error("read byte outside its cycle");
  unused_zero_a: assert property (req.rd && req.addr > WA_VECT |=>
    rdata[7:0] == RD_UNUSED) else $error("unused address not zero");
  drive_low_only_a: assert property (line_out == 48'h0)
    else $error("line driven high");
  unlock_key_a: assert property ($rose(enh_mode) |->
    $past(req.wr && req.addr == 6'h07 && req.wdata == KEY3))
    else $error("enhanced mode without final key");
  // soft reset drops the mode two edges after its write, so skip both
  mode_holds_a: assert property (enh_mode && !srst_wr &&
    !$past(srst_wr) |=> enh_mode) else $error("enhanced mode lost");
  masked_keep_a: assert property (req.wr && mask_hit |=>
    $stable(line_oe)) else $error("masked port written");
  irq_enh_a: assert property (irq_req |-> $past(enh_mode))
    else $error("interrupt in standard mode");
  vect_read_a: assert property (req.rd && req.addr == WA_VECT |=>
    rdata[7:0] == irq_vector) else $error("vector readback differs");
endmodule

bind bdio_port bdio_port_monitor i_bdio_port_monitor (.clk(clk),
  .arst_n(arst_n), .req(req), .rdata(rdata), .ack(ack), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .irq_req(irq_req),
  .irq_vector(irq_vector), .enh_mode(enh_mode));

//--- bench/bdio_field_model.sv
// field wiring beside the port: pull-ups, outside drivers, sinks
`timescale 1ns/1ps
module bdio_field_model (
  // port side
  input wire logic [47:0] line_oe,
  input wire logic [47:0] line_out,
  // outside world, 1 pulls the pin low
  input wire logic [47:0] ext_low,
  // resolved pin level
  output logic [47:0] line_in
);
  // a sink always wins over the pull-up; a released pin reads high unless ext_low pulls it low
  assign line_in = (line_oe & line_out) | (~line_oe & ~ext_low);
endmodule

//--- bench/test_bdio_port.sv
// self-checking bench for the banked digital i/o port
`timescale 1ns/1ps
module test_bdio_port import bdio_pkg::*; ();
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  bdio_req_type req = '0;
  logic [15:0] rdata;
  logic ack;
  logic [47:0] line_in;
  logic [47:0] line_out;
  logic [47:0] line_oe;
  logic [47:0] ext_low = '0;
  logic irq_req;
  logic [7:0] irq_vector;
  logic enh_mode;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int k;

  always #12.5 clk = ~clk;

  // short debounce periods keep the run brief
  bdio_port #(.DB_C0(2), .DB_C1(4), .DB_C2(8), .DB_C3(16)) i_bdio_port (
    .clk(clk), .arst_n(arst_n), .req(req), .rdata(rdata), .ack(ack),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .irq_req(irq_req), .irq_vector(irq_vector), .enh_mode(enh_mode));
  bdio_field_model i_bdio_field_model (.line_oe(line_oe),
    .line_out(line_out), .ext_low(ext_low), .line_in(line_in));

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check({32'h0, rdata}, {32'h0, HI_BYTE, exp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic unlock();
    wr(6'h07, KEY0);
    wr(6'h07, KEY1);
    wr(6'h07, KEY2);
    wr(6'h07, KEY3);
  endtask
  // pin 0 held low for n cycles, then released: a logical falling edge
  task automatic pulse(input int n);
    @(posedge clk) ext_low[0] <= 1'b1;
    idle(n);
    ext_low[0] <= 1'b0;
    idle(14);
  endtask
  task automatic done(input string name);
    $display("test %s over, %0d mismatches so far", name, n_errors);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    idle(20);
    arst_n <= 1'b1;
    #1;
    check(enh_mode, 1'b0);
    check(line_oe, OUT_RST);
    check({irq_req, irq_vector}, 9'h000);
    rd(6'h07, 8'h00);
    done("reset");
    for (k = 0; k < 6; k++) begin
      wr(k[5:0], 8'((k + 1) * 16));
      idle(5);
      check(line_oe[k*8 +: 8], 8'((k + 1) * 16));
      rd(k[5:0], 8'((k + 1) * 16));
    end
    @(posedge clk) ext_low[23:16] <= 8'h0f;
    idle(6);
    rd(6'h02, 8'h3f);
    @(posedge clk) ext_low <= '0;
    done("ports");
    wr(6'h07, 8'hc5); // bank bits ignored in standard mode
    rd(6'h07, 8'h05);
    wr(6'h00, 8'hff);
    wr(6'h02, 8'hff);
    wr(6'h01, 8'h00);
    idle(5);
    rd(6'h00, 8'h10);
    check(line_oe[23:0], 24'h300010);
    wr(6'h07, 8'h00);
    done("mask");
    rd(6'h06, RD_UNUSED);
    rd(6'h12, RD_UNUSED);
    rd(6'h3f, RD_UNUSED);
    done("unused");
    wr(6'h07, KEY0);
    wr(6'h07, KEY1);
    rd(6'h00, 8'h10); // other access breaks the sequence
    wr(6'h07, KEY2);
    wr(6'h07, KEY3);
    idle(2);
    check(enh_mode, 1'b0);
    wr(WA_CTRL, 8'h01);
    unlock();
    idle(2);
    check(enh_mode, 1'b0);
    wr(WA_CTRL, 8'h00);
    unlock();
    idle(2);
    check(enh_mode, 1'b1);
    rd(6'h07, KEY3);
    done("unlock");
    wr(6'h07, 8'h40);
    rd(6'h07, 8'h40);
    wr(6'h06, 8'h01);
    rd(6'h06, 8'h01);
    rd(6'h00, 8'h00);
    wr(WA_VECT, 8'ha5);
    rd(WA_VECT, 8'ha5);
    wr(WA_CTRL, 8'h01);
    rd(WA_CTRL, 8'h01);
    pulse(20);
    check(irq_req, 1'b1);
    rd(6'h00, 8'h01);
    wr(6'h00, 8'h01);
    idle(3);
    rd(6'h00, 8'h00);
    check(irq_req, 1'b0);
    done("events");
    wr(6'h07, 8'h80);
    wr(6'h02, 8'h01);
    wr(6'h03, 8'h00);
    rd(6'h02, 8'h01);
    rd(6'h07, 8'h80);
    pulse(2);
    wr(6'h07, 8'h40);
    rd(6'h00, 8'h00);
    pulse(40);
    rd(6'h00, 8'h01);
    done("debounce");
    wr(6'h00, 8'h01);
    wr(6'h07, 8'h80);
    wr(6'h00, 8'h01);
    rd(6'h00, 8'h01);
    wr(6'h07, 8'h40);
    rd(6'h00, 8'h00);
    @(posedge clk) ext_low[0] <= 1'b1;
    idle(14);
    rd(6'h00, 8'h01);
    wr(6'h00, 8'h01);
    @(posedge clk) ext_low[0] <= 1'b0;
    idle(14);
    rd(6'h00, 8'h00);
    done("polarity");
    wr(WA_CTRL, 8'h02);
    idle(3);
    check(enh_mode, 1'b0);
    check(irq_vector, 8'ha5);
    check(line_oe, OUT_RST);
    rd(6'h07, 8'h00);
    rd(WA_CTRL, 8'h00);
    done("soft reset");
    wrap_up();
  end
endmodule
